/* hw/kms_scanner.sv */
// What this block does
// - per-key mask, one suppresses, resets all set
// - read-only register shows masked pending events
// - sensed key sets its pending bit
// - writing one clears that pending bit only
// - clear register reads unmasked pending bits
// - scan only while scanner_on is set
// - polarity bit: one active high, zero low
// - single mode accepts only one key
// - clear_after_read clears live state on read
// - flush bit clears live state, self-clears
// - four sense enables, bits 7 to 4
// - four drive enables, bits 3 to 0
// - 13-bit period, rate is clock over count+1
// - live state updates once per full sweep of the enabled drive lines
// - key drive s, sense k at bit 4s+k
//
// Decided for this implementation: the AXI4-Lite register port.
`include "kms_map.svh"
module kms_scanner
    import kms_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // key matrix
    output logic [3:0] drive_line,
    output logic [3:0] drive_line_oe,
    input wire logic [3:0] sense_line,
    // interrupt
    output logic irq
);
    logic [15:0] mask_ff;
    logic [15:0] pend_ff;
    logic [15:0] live_ff;
    logic [15:0] scan_acc_ff;
    kms_setup_s setup_ff;
    kms_lines_s lines_ff;
    logic [12:0] period_ff;
    logic [12:0] div_ff;
    logic [1:0] row_ff;
    logic [3:0] sense_s1_ff;
    logic [3:0] sense_s2_ff;
    logic aw_ff;
    logic w_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic wr_go;
    logic rd_go;
    logic tick;
    logic wrap;
    logic [2:0] nxt_row;
    logic row_found;
    logic [3:0] sense_act;
    logic [15:0] hit;
    logic [15:0] accept;
    logic [15:0] next_acc;
    logic live_clear;
    logic [31:0] nxt_rdata;
    logic rd_ok;
    logic [15:0] pend_clr;
    logic [15:0] pend_set;

    // register word indices, compared against address bits 7:2
    localparam logic [5:0] IDX_MASK = 6'(`KMS_OFF_MASK >> 2);
    localparam logic [5:0] IDX_MPEND = 6'(`KMS_OFF_MPEND >> 2);
    localparam logic [5:0] IDX_CLEAR = 6'(`KMS_OFF_CLEAR >> 2);
    localparam logic [5:0] IDX_SETUP = 6'(`KMS_OFF_SETUP >> 2);
    localparam logic [5:0] IDX_LINES = 6'(`KMS_OFF_LINES >> 2);
    localparam logic [5:0] IDX_PERIOD = 6'(`KMS_OFF_PERIOD >> 2);
    localparam logic [5:0] IDX_LIVE = 6'(`KMS_OFF_LIVE >> 2);

    // a channel latched earlier or offered now both count
    assign wa = aw_ff ? awaddr_ff : s_axi_awaddr;
    assign wd = w_ff ? wdata_ff : s_axi_wdata;
    assign ws = w_ff ? wstrb_ff : s_axi_wstrb;
    assign s_axi_awready = !aw_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_ff && !s_axi_bvalid;
    assign wr_go = !s_axi_bvalid && (aw_ff || s_axi_awvalid) && (w_ff || s_axi_wvalid);
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end
        else if (wr_go)
        begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `KMS_RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            case (wa[7:2])
                // read-only words accept and ignore writes
                IDX_MASK, IDX_CLEAR, IDX_SETUP, IDX_LINES, IDX_PERIOD, IDX_MPEND,
                IDX_LIVE: s_axi_bresp <= `KMS_RESP_OKAY;
                default: s_axi_bresp <= `KMS_RESP_SLVERR;
            endcase
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // control registers, byte lanes honoured
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mask_ff <= `KMS_RST_MASK;
            setup_ff <= '0;
            lines_ff <= '0;
            period_ff <= `KMS_RST_PERIOD;
        end
        else if (wr_go)
        begin
            case (wa[7:2])
                IDX_MASK:
                begin
                    if (ws[0]) mask_ff[7:0] <= wd[7:0];
                    if (ws[1]) mask_ff[15:8] <= wd[15:8];
                end
                IDX_SETUP:
                    if (ws[0])
                        setup_ff <= {wd[`KMS_BIT_ON], wd[`KMS_BIT_POL],
                                     wd[`KMS_BIT_SINGLE], wd[`KMS_BIT_CAR]};
                IDX_LINES:
                    if (ws[0]) lines_ff <= wd[7:0];
                IDX_PERIOD:
                begin
                    if (ws[0]) period_ff[7:0] <= wd[7:0];
                    if (ws[1]) period_ff[12:8] <= wd[12:8];
                end
                default: ;
            endcase
        end
    end

    // scan timing: one tick every period_ff+1 clocks
    assign tick = setup_ff.scanner_on && (div_ff == 13'h0000);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            div_ff <= `KMS_RST_PERIOD;
        // preloaded while stopped so the first tick comes one period after start
        else if (!setup_ff.scanner_on || div_ff == 13'h0000)
            div_ff <= period_ff;
        else
            div_ff <= div_ff - 13'h0001;
    end

    // next enabled row after the current one
    always_comb
    begin
        nxt_row = 3'd0;
        row_found = 1'b0;
        for (int i = 1; i <= 4; i++)
        begin
            if (!row_found && lines_ff.drive_on[2'(row_ff + 2'(i))])
            begin
                nxt_row = {1'b0, 2'(row_ff + 2'(i))};
                row_found = 1'b1;
            end
        end
    end
    // a full sweep ends when stepping does not move forward
    assign wrap = !row_found || (nxt_row[1:0] <= row_ff);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            row_ff <= 2'd0;
        // disabled lines are skipped; enable changes apply at the next tick
        else if (tick && row_found)
            row_ff <= nxt_row[1:0];
    end

    // only the current enabled row is driven, idle level elsewhere
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_drive
            logic act;
            assign act = setup_ff.scanner_on && lines_ff.drive_on[g] && (row_ff == 2'(g));
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    drive_line[g] <= 1'b1;
                    drive_line_oe[g] <= 1'b0;
                end
                else
                begin
                    drive_line[g] <= act ~^ setup_ff.polarity_high;
                    drive_line_oe[g] <= setup_ff.scanner_on && lines_ff.drive_on[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sense_s1_ff <= 4'h0;
            sense_s2_ff <= 4'h0;
        end
        else
        begin
            sense_s1_ff <= sense_line;
            sense_s2_ff <= sense_s1_ff;
        end
    end

    // sampled at end of the drive period, after lines settle
    // drive register plus synchroniser is three clocks: periods below 3
    // would credit keys to the wrong drive line
    assign sense_act = (setup_ff.polarity_high ? sense_s2_ff : ~sense_s2_ff)
                       & lines_ff.sense_on;
    always_comb
    begin
        hit = 16'h0000;
        hit[{row_ff, 2'b00} +: 4] = lines_ff.drive_on[row_ff] ? sense_act : 4'h0;
        next_acc = scan_acc_ff | hit;
        accept = next_acc;
        // single mode: a sweep with more than one key yields nothing
        if (setup_ff.single_key && ($countones(next_acc) > 1))
            accept = 16'h0000;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !setup_ff.scanner_on)
            scan_acc_ff <= 16'h0000;
        else if (tick)
            scan_acc_ff <= wrap ? 16'h0000 : next_acc;
    end

    assign live_clear = (wr_go && wa[7:2] == IDX_SETUP && ws[0]
                         && wd[`KMS_BIT_FLUSH])
                        || (rd_go && s_axi_araddr[7:2] == IDX_LIVE
                            && setup_ff.clear_after_read);
    // a sweep ending together with a clear keeps its fresh value
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            live_ff <= 16'h0000;
        else if (tick && wrap)
            live_ff <= accept;
        else if (live_clear)
            live_ff <= 16'h0000;
    end

    // clear only the lanes written; set wins over a clear in the same cycle
    always_comb
    begin
        pend_clr = 16'h0000;
        pend_set = 16'h0000;
        if (wr_go && wa[7:2] == IDX_CLEAR)
        begin
            if (ws[0])
                pend_clr[7:0] = wd[7:0];
            if (ws[1])
                pend_clr[15:8] = wd[15:8];
        end
        if (tick && wrap)
            pend_set = accept;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pend_ff <= 16'h0000;
        else
            pend_ff <= (pend_ff & ~pend_clr) | pend_set;
    end

    assign irq = |(pend_ff & ~mask_ff);

    // unmapped words read zero and answer with an error
    always_comb
    begin
        rd_ok = 1'b1;
        nxt_rdata = 32'h0000_0000;
        case (s_axi_araddr[7:2])
            IDX_MASK: nxt_rdata[15:0] = mask_ff;
            IDX_MPEND: nxt_rdata[15:0] = pend_ff & ~mask_ff;
            IDX_CLEAR: nxt_rdata[15:0] = pend_ff;
            IDX_SETUP:
            begin
                nxt_rdata[`KMS_BIT_ON] = setup_ff.scanner_on;
                nxt_rdata[`KMS_BIT_POL] = setup_ff.polarity_high;
                nxt_rdata[`KMS_BIT_SINGLE] = setup_ff.single_key;
                nxt_rdata[`KMS_BIT_CAR] = setup_ff.clear_after_read;
            end
            IDX_LINES: nxt_rdata[7:0] = lines_ff;
            IDX_PERIOD: nxt_rdata[12:0] = period_ff;
            IDX_LIVE: nxt_rdata[15:0] = live_ff;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `KMS_RESP_OKAY;
        end
        else if (rd_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= nxt_rdata;
            s_axi_rresp <= rd_ok ? `KMS_RESP_OKAY : `KMS_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule // kms_scanner

/* pkg/kms_map.svh */
`ifndef KMS_MAP_SVH
`define KMS_MAP_SVH
`define KMS_OFF_MASK 8'h00
`define KMS_OFF_MPEND 8'h04
`define KMS_OFF_CLEAR 8'h08
`define KMS_OFF_SETUP 8'h0C
`define KMS_OFF_LINES 8'h10
`define KMS_OFF_PERIOD 8'h14
`define KMS_OFF_LIVE 8'h18
`define KMS_RST_MASK 16'hFFFF
`define KMS_RST_PERIOD 13'h1FFF
`define KMS_BIT_ON 5
`define KMS_BIT_POL 4
`define KMS_BIT_SINGLE 3
`define KMS_BIT_CAR 1
`define KMS_BIT_FLUSH 0
`define KMS_RESP_OKAY 2'h0
`define KMS_RESP_SLVERR 2'h2
`endif

/* pkg/kms_pkg.sv */
package kms_pkg;
    typedef struct packed {
        logic [3:0] sense_on;
        logic [3:0] drive_on;
    } kms_lines_s;
    typedef struct packed {
        logic scanner_on;
        logic polarity_high;
        logic single_key;
        logic clear_after_read;
    } kms_setup_s;
endpackage

/* tb/kms_keys.sv */
module kms_keys (
    // scan side
    input wire logic [3:0] drive_line,
    input wire logic [3:0] drive_line_oe,
    input wire logic pol,
    input wire logic [15:0] keys,
    // sense side
    output logic [3:0] sense_line
);
    timeunit 1ns;
    timeprecision 1ns;
    always_comb
    begin
        // idle lines sit at the pull level
        sense_line = {4{~pol}};
        for (int s = 0; s < 4; s++)
            for (int k = 0; k < 4; k++)
                if (keys[4*s+k] && drive_line_oe[s] && drive_line[s] == pol)
                    sense_line[k] = pol;
    end
endmodule // kms_keys

/* tb/kms_scanner_checker.sv */
module kms_scanner_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // matrix and interrupt
    input wire logic [3:0] drive_line,
    input wire logic [3:0] drive_line_oe,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WR_RESP: assert property (s_wr |=> s_axi_bvalid)
        else $error("write response missing");
    AST_RD_RESP: assert property (s_rd |=> s_axi_rvalid)
        else $error("read response missing");
    AST_B_HOLD: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
        else $error("bvalid dropped early");
    AST_R_HOLD: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
        else $error("rvalid dropped early");
    // the one line at the odd level must be an enabled one
    AST_ODD_LINE_OE: assert property (
        ($countones(drive_line) != 3 || (~drive_line & ~drive_line_oe) == 4'h0)
        && ($countones(drive_line) != 1 || (drive_line & ~drive_line_oe) == 4'h0))
        else $error("disabled drive line active");
    AST_ONE_DRIVE: assert property ($countones(drive_line) != 2)
        else $error("two drive lines active");
    AST_IDLE_OFF: assert property (drive_line_oe == 4'h0 |-> drive_line inside {4'h0, 4'hF})
        else $error("drive active while off");
    AST_IRQ_FALL: assert property ($fell(irq) |-> s_axi_bvalid)
        else $error("irq fell without write");
endmodule // kms_scanner_checker

bind kms_scanner kms_scanner_checker chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .drive_line, .drive_line_oe, .irq);

/* tb/tb_kms_scanner.sv */
`include "kms_map.svh"
`define CHK(n, e, v) \
    begin \
        samples_checked++; \
        if ((v) !== (e)) \
        begin \
            mismatches++; \
            $display("ERROR %s exp %h got %h", n, e, v); \
        end \
    end
module tb_kms_scanner;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pol = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q_v;
    logic [3:0] s_axi_wstrb = 4'hF, drive_line, drive_line_oe, sense_line;
    logic [15:0] keys = 16'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, r_v;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    int mismatches = 0;
    int samples_checked = 0;
    kms_scanner dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .drive_line,
        .drive_line_oe, .sense_line, .irq);
    kms_keys keys_u (.drive_line, .drive_line_oe, .pol, .keys, .sense_line);
    initial forever #5 aclk = ~aclk;
    task automatic results();
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if ((w ? s_axi_bvalid : s_axi_rvalid) === 1'b1) break;
        end
        q_v = s_axi_rdata;
        r_v = w ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (n == 50)
        begin
            mismatches++;
            results();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, q_v)
    endtask
    // one full sweep at period 3 is at most 16 clocks
    task automatic sweep_wait();
        repeat (80) @(posedge aclk);
    endtask
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK("drive", 4'hF, drive_line)
        rd(`KMS_OFF_MASK, 32'h0000FFFF);
        rd(`KMS_OFF_PERIOD, 32'h00001FFF);
        rd(`KMS_OFF_LINES, 32'h0);
        bus(1'b1, 8'h1C, 32'h1);
        `CHK("bresp", `KMS_RESP_SLVERR, r_v)
        rd(8'h1C, 32'h0);
        `CHK("rresp", `KMS_RESP_SLVERR, r_v)
        bus(1'b1, `KMS_OFF_PERIOD, 32'h3);
        rd(`KMS_OFF_PERIOD, 32'h3);
        bus(1'b1, `KMS_OFF_LINES, 32'hFF);
        bus(1'b1, `KMS_OFF_SETUP, 32'h20);
        keys <= 16'h0200;
        sweep_wait();
        rd(`KMS_OFF_LIVE, 32'h200);
        rd(`KMS_OFF_CLEAR, 32'h200);
        rd(`KMS_OFF_MPEND, 32'h0);
        `CHK("irq", 1'b0, irq)
        bus(1'b1, `KMS_OFF_MASK, 32'hFDFF);
        `CHK("irq", 1'b1, irq)
        rd(`KMS_OFF_MPEND, 32'h200);
        keys <= 16'h0;
        sweep_wait();
        rd(`KMS_OFF_LIVE, 32'h0);
        bus(1'b1, `KMS_OFF_CLEAR, 32'hFDFF);
        rd(`KMS_OFF_CLEAR, 32'h200);
        bus(1'b1, `KMS_OFF_CLEAR, 32'h200);
        rd(`KMS_OFF_CLEAR, 32'h0);
        `CHK("irq", 1'b0, irq)
        // stop first so the pull swap is not seen as keys
        bus(1'b1, `KMS_OFF_SETUP, 32'h0);
        pol <= 1'b1;
        keys <= 16'h8001;
        bus(1'b1, `KMS_OFF_SETUP, 32'h30);
        sweep_wait();
        rd(`KMS_OFF_LIVE, 32'h8001);
        rd(`KMS_OFF_CLEAR, 32'h8001);
        bus(1'b1, `KMS_OFF_CLEAR, 32'hFFFF);
        bus(1'b1, `KMS_OFF_LINES, 32'hEF);
        sweep_wait();
        rd(`KMS_OFF_LIVE, 32'h8000);
        bus(1'b1, `KMS_OFF_LINES, 32'hFE);
        sweep_wait();
        `CHK("oe", 4'hE, drive_line_oe)
        rd(`KMS_OFF_LIVE, 32'h8000);
        bus(1'b1, `KMS_OFF_LINES, 32'hFF);
        bus(1'b1, `KMS_OFF_SETUP, 32'h38);
        sweep_wait();
        rd(`KMS_OFF_LIVE, 32'h0);
        keys <= 16'h0001;
        sweep_wait();
        rd(`KMS_OFF_LIVE, 32'h1);
        bus(1'b1, `KMS_OFF_SETUP, 32'h10);
        keys <= 16'h0010;
        sweep_wait();
        rd(`KMS_OFF_CLEAR, 32'h8001);
        `CHK("oe", 4'h0, drive_line_oe)
        rd(`KMS_OFF_LIVE, 32'h1);
        rd(`KMS_OFF_LIVE, 32'h1);
        bus(1'b1, `KMS_OFF_SETUP, 32'h12);
        rd(`KMS_OFF_LIVE, 32'h1);
        rd(`KMS_OFF_LIVE, 32'h0);
        bus(1'b1, `KMS_OFF_SETUP, 32'h30);
        sweep_wait();
        bus(1'b1, `KMS_OFF_SETUP, 32'h10);
        rd(`KMS_OFF_LIVE, 32'h10);
        bus(1'b1, `KMS_OFF_SETUP, 32'h11);
        rd(`KMS_OFF_LIVE, 32'h0);
        rd(`KMS_OFF_SETUP, 32'h10);
        results();
    end
endmodule // tb_kms_scanner
